// ==== design/fps_top.sv ====
/*
  Protection sequencer of a quasi-resonant flyback controller: gates
  the drive from qualified comparator results, counts faults in
  switching cycles, latches them, controls supply charging.
  Assumes comparator inputs are asynchronous to core_clk; the pulse
  request comes from the modulator on core_clk.
*/
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module fps_top
  import fps_pkg::*;
#(
  parameter int BRIN_CYC  = (`FPS_BRIN_NS / `FPS_CLK_NS),
  parameter int BROUT_CYC = (`FPS_BROUT_MS * (`FPS_CLK_HZ / 1000)),
  parameter int CTLL_CYC  = (`FPS_CTRL_LOW_MS * (`FPS_CLK_HZ / 1000)),
  parameter int BLANK_CYC = (`FPS_OUTPUT_UNDERVOLT_FAULT_BLANK_MS * (`FPS_CLK_HZ / 1000))
) (
  input  wire logic        core_clk,   // 25 MHz clock
  input  wire logic        rst,        // Async reset, active high
  input  wire fps_cmp_t    cmp_in,     // Analog comparator results
  input  wire logic        pwm_req,    // Modulator asks for gate on
  input  wire logic [3:0]  reg_addr,   // Register address
  input  wire logic [7:0]  reg_wdata,  // Register write data
  input  wire logic        reg_wr,     // Write strobe
  input  wire logic        reg_rd,     // Read strobe
  output logic      [7:0]  reg_rdata,  // Read data, cycle after strobe
  output var fps_drive_t   drive_out,  // Gate and charge controls
  output logic             irq         // Level interrupt
);

  // -------------------------------------------------------------
  // Constants and input synchronisers
  // -------------------------------------------------------------
  localparam int CMPW     = $bits(fps_cmp_t);
  localparam int CNTW     = 24;
  localparam int SENSE_SHORT_FAULT_CYC = (`FPS_SENSE_SHORT_FAULT_NS / `FPS_CLK_NS);
  localparam int LEB_CYC  = (`FPS_LEB_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS;
  localparam int SMP_CYC  = (`FPS_SAMPLE_NS / `FPS_CLK_NS);
  localparam logic [2:0] FCYC = 3'(`FPS_FAULT_CYCLES);

  logic [CMPW-1:0] s1_q, s2_q, s3_q, cmp_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      cmp_q <= '0;
    end else begin
      s1_q <= cmp_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < CMPW; i++) begin
        if (s2_q[i] == s3_q[i]) cmp_q[i] <= s3_q[i];
      end
    end
  end
  fps_cmp_t c;
  assign c = fps_cmp_t'(cmp_q);

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  fps_state_t st_q, st_d;
  logic [7:0] ctrl_q, int_en_q, status_q, fault_q;
  logic [7:0] ev_set, flt_set;
  logic       gate_q, gate_d;
  logic       otp_q;

  wire wr_ctrl = reg_wr && (reg_addr == `FPS_ADDR_CTRL);
  wire wr_en   = reg_wr && (reg_addr == `FPS_ADDR_INT_EN);
  wire wr_clr  = reg_wr && (reg_addr == `FPS_ADDR_INT_CLR);
  wire sw_en   = ctrl_q[`FPS_CTRL_EN_BIT];

  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `FPS_ADDR_CTRL:   rd_mux = ctrl_q;
      `FPS_ADDR_STATUS: rd_mux = status_q;
      `FPS_ADDR_INT_EN: rd_mux = int_en_q;
      `FPS_ADDR_FAULTS: rd_mux = fault_q;
      `FPS_ADDR_STATE:  rd_mux = {5'h0_0, otp_q, st_q};
      default:          rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q    <= `FPS_CTRL_RESET;
      int_en_q  <= 8'h00;
      status_q  <= 8'h00;
      reg_rdata <= 8'h00;
      irq       <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= reg_wdata;
      if (wr_en) int_en_q <= reg_wdata;
      // Set wins over a clear in the same cycle
      status_q  <= (status_q & ~(wr_clr ? reg_wdata : 8'h00)) | ev_set;
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
      irq       <= |(((status_q & ~(wr_clr ? reg_wdata : 8'h00))
                      | ev_set) & int_en_q);
    end
  end

  // -------------------------------------------------------------
  // Gate edges and per-cycle sample points
  // -------------------------------------------------------------
  logic       gate_d1_q;
  logic [7:0] on_cnt_q, off_cnt_q;
  wire gate_rise = gate_q & ~gate_d1_q;
  wire gate_fall = ~gate_q & gate_d1_q;
  // Counters hold the last pulse's count on the edge cycle itself
  wire smp_off = (off_cnt_q == 8'(SMP_CYC)) && !gate_q && !gate_fall;
  wire smp_on  = (on_cnt_q == 8'(SENSE_SHORT_FAULT_CYC)) && gate_q && !gate_rise;
  wire leb_act = gate_q && (gate_rise || on_cnt_q < 8'(LEB_CYC));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gate_d1_q <= 1'b0;
      on_cnt_q  <= 8'h00;
      off_cnt_q <= 8'h00;
    end else begin
      gate_d1_q <= gate_q;
      if (gate_rise) on_cnt_q <= 8'h01;
      else if (gate_q && on_cnt_q != 8'hFF) on_cnt_q <= on_cnt_q + 8'h01;
      if (gate_fall) off_cnt_q <= 8'h01;
      else if (!gate_q && off_cnt_q != 8'hFF && off_cnt_q != 8'h00)
        off_cnt_q <= off_cnt_q + 8'h01;
    end
  end

  // -------------------------------------------------------------
  // Seven-cycle fault counters, one per switching-cycle fault
  // -------------------------------------------------------------
  logic [5:0] hit, stb;
  logic [2:0] run_q [6];
  logic       blank_done;
  assign stb = {smp_off, smp_on, gate_fall, gate_fall, smp_off, smp_off};
  assign hit[`FPS_EV_OUTPUT_OVERVOLT_FAULT] = c.demag_above_ovp;
  assign hit[`FPS_EV_OUTPUT_UNDERVOLT_FAULT] = c.demag_below_uvp && blank_done;
  assign hit[`FPS_EV_LINE_OVERVOLT_FAULT] = c.line_above_ovp;
  assign hit[`FPS_EV_FAST_OVERCURRENT_FAULT] = c.sense_above_fast_overcurrent_fault;
  assign hit[`FPS_EV_SENSE_SHORT_FAULT] = c.sense_below_sense_short_fault;
  assign hit[`FPS_EV_CTLH] = c.ctrl_above_high;

  logic [5:0] trip;
  always_comb begin
    for (int i = 0; i < 6; i++)
      trip[i] = stb[i] && hit[i] && (run_q[i] == FCYC - 3'd1);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 6; i++) run_q[i] <= 3'd0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (st_q != FPS_ST_RUN) run_q[i] <= 3'd0;
        else if (stb[i]) run_q[i] <= hit[i] ? run_q[i] + 3'd1 : 3'd0;
      end
    end
  end

  // -------------------------------------------------------------
  // Time-based qualifiers
  // -------------------------------------------------------------
  logic [CNTW-1:0] brin_q, brout_q, ctll_q, blank_q;
  wire brin_ok  = (brin_q >= CNTW'(BRIN_CYC));
  wire brout_tr = (brout_q >= CNTW'(BROUT_CYC));
  wire ctll_tr  = (ctll_q >= CNTW'(CTLL_CYC));
  assign blank_done = (blank_q >= CNTW'(BLANK_CYC));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      brin_q  <= '0;
      brout_q <= '0;
      ctll_q  <= '0;
      blank_q <= '0;
    end else begin
      brin_q  <= !c.line_above_brin ? '0 : brin_ok ? brin_q : brin_q + 1'b1;
      brout_q <= !c.line_below_brout ? '0 : brout_tr ? brout_q
                 : brout_q + 1'b1;
      ctll_q  <= (!c.ctrl_below_low || st_q != FPS_ST_RUN) ? '0
                 : ctll_tr ? ctll_q : ctll_q + 1'b1;
      blank_q <= (st_q != FPS_ST_RUN) ? '0 : blank_done ? blank_q
                 : blank_q + 1'b1;
    end
  end

  // -------------------------------------------------------------
  // Fault latch and over-temperature
  // -------------------------------------------------------------
  always_comb begin
    flt_set = 8'h00;
    flt_set[5:0] = trip;
    flt_set[`FPS_EV_CTLL] = ctll_tr && st_q == FPS_ST_RUN;
    flt_set[`FPS_EV_OTP]  = c.temp_above_otp && !otp_q;
  end
  assign ev_set = flt_set;
  wire supply_ovp = c.vcc_above_ovp && st_q == FPS_ST_RUN;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault_q <= 8'h00;
      otp_q   <= 1'b0;
    end else begin
      // Hysteresis: set at trip level, release below recovery level
      if (c.temp_above_otp) otp_q <= 1'b1;
      else if (c.temp_below_recover) otp_q <= 1'b0;
      if (st_q == FPS_ST_FAULT && c.vcc_below_uvlo)
        fault_q <= flt_set;
      else
        fault_q <= fault_q | flt_set;
    end
  end
  wire any_fault = |fault_q[6:0] || |flt_set[6:0] || supply_ovp;

  // -------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      FPS_ST_OFF:  if (brin_ok) st_d = FPS_ST_QUAL;
      FPS_ST_QUAL: begin
        if (!brin_ok) st_d = FPS_ST_OFF;
        else if (c.vcc_above_start && sw_en) st_d = FPS_ST_RUN;
      end
      FPS_ST_RUN: begin
        if (any_fault) st_d = FPS_ST_FAULT;
        else if (brout_tr) st_d = FPS_ST_OFF;
      end
      FPS_ST_FAULT: if (c.vcc_below_uvlo) st_d = FPS_ST_OFF;
      default: st_d = FPS_ST_OFF;
    endcase
  end

  // Gate: held on through blanking while running, no new pulse during burst, off while over-temp
  always_comb begin
    gate_d = 1'b0;
    if (st_d == FPS_ST_RUN && !otp_q) begin
      if (leb_act) gate_d = 1'b1;
      else gate_d = pwm_req && !c.fb_below_burst
                    && !(gate_q && c.sense_above_limit);
    end
  end

  // After a fault restart the supply recharges at the reduced current
  // until it reaches the start level again
  logic rcv_q;
  wire  fault_chg = (st_q == FPS_ST_FAULT && c.vcc_below_uvlo)
                    || (rcv_q && !c.vcc_above_start);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q      <= FPS_ST_OFF;
      gate_q    <= 1'b0;
      rcv_q     <= 1'b0;
      drive_out <= '0;
    end else begin
      st_q   <= st_d;
      gate_q <= gate_d;
      if (st_q == FPS_ST_FAULT && c.vcc_below_uvlo) rcv_q <= 1'b1;
      else if (c.vcc_above_start) rcv_q <= 1'b0;
      drive_out.gate_drive   <= gate_d;
      drive_out.charge_high  <= !fault_chg && (st_q != FPS_ST_FAULT) &&
        (c.vcc_below_maintain || st_q != FPS_ST_RUN);
      drive_out.charge_fault <= fault_chg;
    end
  end

endmodule : fps_top
`default_nettype wire

// ==== dv/flyback_protection_sequencer_bench.sv ====
/*
  Self-checking bench of fps_top with a stage model.
  Assumes shortened count parameters set below.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fps_consts.svh"
module flyback_protection_sequencer_bench
  import fps_pkg::*;
;
  logic       core_clk = 0, rst = 1, pwm_req = 0, reg_wr = 0, reg_rd = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [6:0] k = 7'h00;
  logic       line_overvolt_fault = 1'b0;
  logic       irq, g;
  fps_cmp_t   cmp_in;
  fps_drive_t drive_out;
  int         n_mismatch = 0, n_checks = 0, cyc = 0;
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  fps_top #(.BRIN_CYC(20), .BROUT_CYC(50), .CTLL_CYC(40), .BLANK_CYC(30))
  dut_u (.core_clk(core_clk), .rst(rst), .cmp_in(cmp_in),
    .pwm_req(pwm_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .drive_out(drive_out), .irq(irq));
  fps_stage_model mdl_u (.gate(drive_out.gate_drive), .k(k), .line_overvolt_fault(line_overvolt_fault),
    .cmp(cmp_in));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc_n(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc_n
  task automatic knob(input logic [6:0] v);
    @(posedge core_clk);
    k <= v;
  endtask : knob
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rdc
  // Ten cycles high, then low past the output sample point
  task automatic pulse();
    @(posedge core_clk);
    pwm_req <= 1'b1;
    cyc_n(5);
    #1 g = drive_out.gate_drive;
    cyc_n(5);
    pwm_req <= 1'b0;
    cyc_n(60);
  endtask : pulse
  task automatic t_start();
    rdc(`FPS_ADDR_CTRL, 8'h01);
    rdc(`FPS_ADDR_STATUS, 8'h00);
    rdc(4'hF, 8'h00);
    knob(7'h03);
    cyc_n(10);
    rdc(`FPS_ADDR_STATE, 8'h00);
    cyc_n(20);
    rdc(`FPS_ADDR_STATE, 8'h02);
    pulse();
    chk({7'h0, g}, 8'h01);
    knob(7'h23);
    cyc_n(8);
    pulse();
    chk({7'h0, g}, 8'h00);
    knob(7'h43);
    cyc_n(8);
    pulse();
    chk({7'h0, g}, 8'h00);
    knob(7'h03);
    cyc_n(8);
  endtask : t_start
  task automatic t_ovp();
    wr(`FPS_ADDR_INT_CLR, 8'hFF);
    wr(`FPS_ADDR_INT_EN, 8'h01);
    knob(7'h0B);
    repeat (6) pulse();
    rdc(`FPS_ADDR_FAULTS, 8'h80);
    chk({7'h0, irq}, 8'h00);
    pulse();
    rdc(`FPS_ADDR_FAULTS, 8'h81);
    rdc(`FPS_ADDR_STATE, 8'h03);
    chk({7'h0, irq}, 8'h01);
    knob(7'h03);
    pulse();
    chk({7'h0, g}, 8'h00);
    wr(`FPS_ADDR_INT_EN, 8'h00);
    cyc_n(2);
    #1 chk({7'h0, irq}, 8'h00);
    wr(`FPS_ADDR_INT_EN, 8'h01);
    cyc_n(2);
    #1 chk({7'h0, irq}, 8'h01);
    wr(`FPS_ADDR_INT_CLR, 8'h01);
    cyc_n(2);
    #1 chk({7'h0, irq}, 8'h00);
    rdc(`FPS_ADDR_STATUS, 8'h00);
  endtask : t_ovp
  task automatic t_uvlo();
    knob(7'h05);
    cyc_n(8);
    #1 chk({7'h0, drive_out.charge_fault}, 8'h01);
    chk({7'h0, drive_out.charge_high}, 8'h00);
    rdc(`FPS_ADDR_STATE, 8'h01);
    rdc(`FPS_ADDR_FAULTS, 8'h00);
    knob(7'h03);
    cyc_n(30);
    rdc(`FPS_ADDR_STATE, 8'h02);
    chk({7'h0, drive_out.charge_high}, 8'h00);
    knob(7'h07);
    cyc_n(8);
    #1 chk({7'h0, drive_out.charge_high}, 8'h01);
    knob(7'h03);
  endtask : t_uvlo
  task automatic t_brownout();
    knob(7'h02);
    cyc_n(35);
    rdc(`FPS_ADDR_STATE, 8'h02);
    cyc_n(20);
    rdc(`FPS_ADDR_STATE, 8'h00);
    pulse();
    chk({7'h0, g}, 8'h00);
    knob(7'h03);
    cyc_n(30);
    rdc(`FPS_ADDR_STATE, 8'h02);
  endtask : t_brownout
  task automatic t_ctrl_low();
    knob(7'h13);
    cyc_n(25);
    rdc(`FPS_ADDR_FAULTS, 8'h00);
    cyc_n(25);
    rdc(`FPS_ADDR_FAULTS, 8'h40);
    pulse();
    chk({7'h0, g}, 8'h00);
  endtask : t_ctrl_low
  // Restart through lockout, then seven line over-voltage cycles
  task automatic t_line_overvolt_fault();
    knob(7'h05);
    cyc_n(8);
    knob(7'h03);
    cyc_n(10);
    rdc(`FPS_ADDR_STATE, 8'h02);
    @(posedge core_clk);
    line_overvolt_fault <= 1'b1;
    repeat (6) pulse();
    rdc(`FPS_ADDR_FAULTS, 8'h00);
    pulse();
    rdc(`FPS_ADDR_FAULTS, 8'h04);
    rdc(`FPS_ADDR_STATE, 8'h03);
  endtask : t_line_overvolt_fault
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  initial begin
    cyc_n(10);
    rst <= 1'b0;
    t_start();
    t_ovp();
    t_uvlo();
    t_brownout();
    t_ctrl_low();
    t_line_overvolt_fault();
    stop_test();
  end
endmodule : flyback_protection_sequencer_bench
`default_nettype wire

// ==== dv/fps_checker.sv ====
/*
  Port checker of fps_top, bound to every instance.
  Assumes one clock domain and an async high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module fps_checker
  import fps_pkg::*;
#(parameter int BROUT_CYC = 50) (
  input wire logic       core_clk,  // Clock
  input wire logic       rst,       // Reset
  input wire fps_cmp_t   cmp_in,    // Comparators
  input wire logic       pwm_req,   // Pulse request
  input wire logic       reg_rd,    // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire fps_drive_t drive_out, // Drive controls
  input wire logic       irq        // Interrupt
);
  logic [31:0] bo_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) bo_q <= '0;
    else bo_q <= cmp_in.line_below_brout ? bo_q + 1 : '0;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_follow;
    $rose(drive_out.gate_drive) |-> $past(pwm_req);
  endproperty
  a_follow: assert property (p_follow)
    else $error("gate rose without request");
  property p_leb;
    $rose(drive_out.gate_drive) |-> drive_out.gate_drive [*7];
  endproperty
  a_leb: assert property (p_leb)
    else $error("gate fell inside blanking");
  property p_burst;
    cmp_in.fb_below_burst [*7] |-> !$rose(drive_out.gate_drive);
  endproperty
  a_burst: assert property (p_burst)
    else $error("pulse during burst");
  property p_otp;
    cmp_in.temp_above_otp [*7] |-> !$rose(drive_out.gate_drive);
  endproperty
  a_otp: assert property (p_otp)
    else $error("pulse during over-temperature");
  property p_fault_low;
    drive_out.charge_fault |-> !drive_out.gate_drive;
  endproperty
  a_fault_low: assert property (p_fault_low)
    else $error("gate high while fault charging");
  property p_fault_cause;
    $rose(drive_out.charge_fault) |-> $past(cmp_in.vcc_below_uvlo, 3);
  endproperty
  a_fault_cause: assert property (p_fault_cause)
    else $error("fault charge without lockout");
  property p_brownout;
    bo_q > BROUT_CYC + 6 |-> !drive_out.gate_drive;
  endproperty
  a_brownout: assert property (p_brownout)
    else $error("gate high after brown-out");
  property p_rdata;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data outside read cycle");
  cover property ($rose(drive_out.gate_drive));
  cover property ($rose(irq));
  cover property ($rose(drive_out.charge_fault));
endmodule : fps_checker
bind fps_top fps_checker #(.BROUT_CYC(BROUT_CYC)) chk_u (
  .core_clk(core_clk), .rst(rst), .cmp_in(cmp_in),
  .pwm_req(pwm_req), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .drive_out(drive_out), .irq(irq));
`default_nettype wire

// ==== dv/fps_stage_model.sv ====
/*
  Power stage and comparators seen by the sequencer.
  Assumes the bench sets the knobs k on core_clk edges.
*/
`timescale 1ns/1ns
`default_nettype none
module fps_stage_model
  import fps_pkg::*;
(
  input  wire logic       gate, // Gate drive from the sequencer
  input  wire logic [6:0] k,    // Line, vcc, uvlo, ov, low, burst, otp
  input  wire logic       line_overvolt_fault, // Line over-voltage level
  output var  fps_cmp_t   cmp   // Comparator levels
);
  always_comb begin
    cmp = '0;
    cmp.line_above_brin    = k[0];
    cmp.line_below_brout   = !k[0];
    cmp.line_above_ovp     = line_overvolt_fault;
    cmp.vcc_above_start    = k[1];
    cmp.vcc_below_uvlo     = k[2];
    cmp.vcc_below_maintain = k[2];
    // Output only shows on demag while the secondary conducts
    cmp.demag_above_ovp    = k[3] && !gate;
    cmp.ctrl_below_low     = k[4];
    cmp.fb_below_burst     = k[5];
    cmp.temp_above_otp     = k[6];
    cmp.temp_below_recover = !k[6];
  end
endmodule : fps_stage_model
`default_nettype wire

// ==== pkg/fps_consts.svh ====
/*
  Constants of the flyback protection sequencer: register offsets,
  field positions, reset values and timing figures.
  Assumes inclusion by bare name from the package and the bench.
*/
`ifndef FPS_CONSTS_SVH
`define FPS_CONSTS_SVH

`define FPS_CLK_HZ          25000000
`define FPS_CLK_NS          40
`define FPS_BRIN_NS         100000
`define FPS_BROUT_MS        50
`define FPS_CTRL_LOW_MS     32
`define FPS_SENSE_SHORT_FAULT_NS         3000
`define FPS_LEB_NS          250
`define FPS_FAULT_CYCLES    7
`define FPS_OUTPUT_UNDERVOLT_FAULT_BLANK_MS   20
`define FPS_SAMPLE_NS       2000

`define FPS_ADDR_CTRL       4'h0
`define FPS_ADDR_STATUS     4'h1
`define FPS_ADDR_INT_EN     4'h2
`define FPS_ADDR_INT_CLR    4'h3
`define FPS_ADDR_FAULTS     4'h4
`define FPS_ADDR_STATE      4'h5

`define FPS_CTRL_RESET      8'h01
`define FPS_CTRL_EN_BIT     0
`define FPS_CTRL_MASK_BIT   1

`define FPS_EV_OUTPUT_OVERVOLT_FAULT         0
`define FPS_EV_OUTPUT_UNDERVOLT_FAULT         1
`define FPS_EV_LINE_OVERVOLT_FAULT         2
`define FPS_EV_FAST_OVERCURRENT_FAULT         3
`define FPS_EV_SENSE_SHORT_FAULT         4
`define FPS_EV_CTLH         5
`define FPS_EV_CTLL         6
`define FPS_EV_OTP          7
`define FPS_NUM_EV          8

`endif

// ==== pkg/fps_pkg.sv ====
/*
  Types of the flyback protection sequencer.
  Assumes fps_consts.svh is on the include path.
*/
`include "fps_consts.svh"
package fps_pkg;

  typedef enum logic [1:0] {
    FPS_ST_OFF   = 2'b00,
    FPS_ST_QUAL  = 2'b01,
    FPS_ST_RUN   = 2'b10,
    FPS_ST_FAULT = 2'b11
  } fps_state_t;

  // Comparator results from the analog front end
  typedef struct packed {
    logic line_above_brin;    // line_sense_input above brown_in_threshold
    logic line_below_brout;   // line_sense_input below brown_out_threshold
    logic line_above_ovp;
    logic demag_above_ovp;    // demag_sense_input vs output over-voltage
    logic demag_below_uvp;
    logic sense_above_fast_overcurrent_fault;
    logic sense_below_sense_short_fault;
    logic sense_above_limit;  // current-limit / modulation comparator
    logic ctrl_above_high;    // protect_pin_high_threshold
    logic ctrl_below_low;     // protect_pin_low_threshold
    logic fb_below_burst;
    logic vcc_above_start;    // supply_start_threshold
    logic vcc_below_uvlo;
    logic vcc_below_maintain;
    logic vcc_above_ovp;
    logic temp_above_otp;
    logic temp_below_recover;
  } fps_cmp_t;

  typedef struct packed {
    logic gate_drive;
    logic charge_high;
    logic charge_fault;
  } fps_drive_t;

endpackage : fps_pkg
